// ---- rtl/gp1_pkg.sv ----
// Summary of operation
// - direction one makes pin an output
// - direction zero makes pin an input
// - output pin drives its latch bit
// - latch write drives output pins one cycle later
// - latch write on input pin not driven
// - normal read of output returns latch
// - normal read of input returns pin
// - read-modify-write read returns latch always
// - peripheral enable drives pin, read shows it
// - open-drain output one floats the pin
// - reset clears all direction bits
// - standby float bit floats pins, blocks inputs
// - wake-enabled pins four, six stay unblocked
// - float bit zero keeps pins unchanged
// - pull-up bit one connects pull-up
// - pull-up off while pin driven low
// - pull-up bit two stored, no effect
package gp1_pkg;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [1:0] OFS_DATA_LATCH = 2'h0;  // port_one_data_latch
    localparam logic [1:0] OFS_DIRECTION  = 2'h1;  // port_one_direction
    localparam logic [1:0] OFS_PULLUP     = 2'h2;  // port_one_pullup_enable
    localparam logic [1:0] OFS_CONTROL    = 2'h3;  // standby and wake control
    // ************************************************************
    // reset values and field positions
    // ************************************************************
    localparam logic [7:0] RST_DATA_LATCH = 8'h00;
    localparam logic [7:0] RST_DIRECTION  = 8'h00;
    localparam logic [7:0] RST_PULLUP     = 8'h00;
    localparam logic [7:0] RST_CONTROL    = 8'h00;
    localparam int CTL_FLOAT_BIT = 0;              // standby_pin_float_bit
    localparam int CTL_WAKE4_BIT = 1;              // wake enable pin four
    localparam int CTL_WAKE6_BIT = 2;              // wake enable pin six
    localparam int PIN_NO_PULLUP = 2;              // pin_two_no_pullup
    localparam int PIN_WAKE_A    = 4;              // pin_four_wake_capable
    localparam int PIN_WAKE_B    = 6;              // pin_six_wake_capable
endpackage : gp1_pkg

// ---- rtl/gp1_port.sv ----
`timescale 1ns/1ps
module gp1_port #(
    parameter int           WIDTH      = 8,
    parameter logic [7:0]   OPEN_DRAIN = 8'h00   // open-drain pin mask
) (
    // clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    // register port
    input  wire logic [1:0]        addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    input  wire logic              rmw_i,         // read belongs to rmw instruction
    output logic      [7:0]        rdata_o,
    // system state
    input  wire logic              standby_i,     // stop or watch mode active
    // peripheral side
    input  wire logic [WIDTH-1:0]  periph_oe_i,
    input  wire logic [WIDTH-1:0]  periph_out_i,
    output logic      [WIDTH-1:0]  periph_in_o,   // gated pin inputs
    // pins
    input  wire logic [WIDTH-1:0]  pin_i,
    output logic      [WIDTH-1:0]  pin_o,
    output logic      [WIDTH-1:0]  pin_oe_o,
    output logic      [WIDTH-1:0]  pullup_en_o
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0]       port_one_data_latch;
    logic [7:0]       port_one_direction;
    logic [7:0]       port_one_pullup_enable;
    logic [7:0]       standby_control_reg;
    logic [WIDTH-1:0] pin_meta;                   // synchroniser stage one
    logic [WIDTH-1:0] pin_sync;                   // synchroniser stage two

    // ************************************************************
    // decode and pin logic
    // ************************************************************
    wire float_all = standby_i & standby_control_reg[gp1_pkg::CTL_FLOAT_BIT];
    logic [WIDTH-1:0] wake_keep;
    logic [WIDTH-1:0] next_drive;
    logic [WIDTH-1:0] next_oe;
    logic [WIDTH-1:0] next_val;
    logic [WIDTH-1:0] next_pu;
    logic [WIDTH-1:0] next_in;
    logic [WIDTH-1:0] normal_rd;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_pin
            if (g == gp1_pkg::PIN_WAKE_A) begin : g_w4
                assign wake_keep[g] = standby_control_reg[gp1_pkg::CTL_WAKE4_BIT];
            end else if (g == gp1_pkg::PIN_WAKE_B) begin : g_w6
                assign wake_keep[g] = standby_control_reg[gp1_pkg::CTL_WAKE6_BIT];
            end else begin : g_nw
                assign wake_keep[g] = 1'b0;
            end
            assign next_val[g]   = periph_oe_i[g] ? periph_out_i[g] : port_one_data_latch[g];
            assign next_drive[g] = periph_oe_i[g] | port_one_direction[g];
            // open drain floats high, standby with float bit floats all
            assign next_oe[g]    = next_drive[g] & ~float_all & ~(OPEN_DRAIN[g] & next_val[g]);
            // pull-up off when driving low, none on pin two
            if (g == gp1_pkg::PIN_NO_PULLUP) begin : g_np
                assign next_pu[g] = 1'b0;
            end else begin : g_pu
                assign next_pu[g] = port_one_pullup_enable[g] & ~(next_oe[g] & ~next_val[g]);
            end
            // input forced low during float unless wake exempt
            assign next_in[g]    = (float_all & ~wake_keep[g]) ? 1'b0 : pin_sync[g];
            assign normal_rd[g]  = (port_one_direction[g] & ~periph_oe_i[g]) ? port_one_data_latch[g] : next_in[g];
        end
    endgenerate

    wire [7:0] rd_latch = rmw_i ? port_one_data_latch : 8'(normal_rd);
    wire [7:0] next_rdata =
        (addr_i == gp1_pkg::OFS_DATA_LATCH) ? rd_latch :
        (addr_i == gp1_pkg::OFS_DIRECTION)  ? port_one_direction :
        (addr_i == gp1_pkg::OFS_PULLUP)     ? port_one_pullup_enable :
                                              {5'h00, standby_control_reg[2:0]};

    // ************************************************************
    // register writes
    // ************************************************************
    // byte-wide registers
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_one_data_latch    <= gp1_pkg::RST_DATA_LATCH;
            port_one_direction     <= gp1_pkg::RST_DIRECTION;
            port_one_pullup_enable <= gp1_pkg::RST_PULLUP;
            standby_control_reg    <= gp1_pkg::RST_CONTROL;
        end else if (wr_i) begin
            if (addr_i == gp1_pkg::OFS_DATA_LATCH) begin
                port_one_data_latch <= wdata_i;
            end else if (addr_i == gp1_pkg::OFS_DIRECTION) begin
                port_one_direction <= wdata_i;
            end else if (addr_i == gp1_pkg::OFS_PULLUP) begin
                port_one_pullup_enable <= wdata_i;
            end else begin
                standby_control_reg <= {5'h00, wdata_i[2:0]};
            end
        end
    end

    // ************************************************************
    // outputs and synchroniser
    // ************************************************************
    // registered outputs, one cycle after register change
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_meta    <= '0;
            pin_sync    <= '0;
            pin_o       <= '0;
            pin_oe_o    <= '0;
            pullup_en_o <= '0;
            periph_in_o <= '0;
            rdata_o     <= 8'h00;
        end else begin
            pin_meta    <= pin_i;
            pin_sync    <= pin_meta;
            pin_o       <= next_val;
            pin_oe_o    <= next_oe;
            pullup_en_o <= next_pu;
            periph_in_o <= next_in;
            rdata_o     <= rd_i ? next_rdata : 8'h00;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_reset_dir;
        @(posedge clk_sys_i) $rose(rst_n_i) |-> port_one_direction == 8'h00;
    endproperty
    a_reset_dir: assert property (p_reset_dir) else $error("direction not cleared");
    property p_drive;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (!float_all && port_one_direction[1] && !periph_oe_i[1] && !OPEN_DRAIN[1])
            |=> pin_oe_o[1] && pin_o[1] == $past(port_one_data_latch[1]);
    endproperty
    a_drive: assert property (p_drive) else $error("output pin not driven");
    // open-drain pin with latch one must let go of the pad
    property p_open_drain;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (!float_all && port_one_direction[0] && !periph_oe_i[0] && OPEN_DRAIN[0] && port_one_data_latch[0])
            |=> !pin_oe_o[0];
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open-drain pin driven high");
    // wake-enabled pin four keeps its input during float
    property p_wake;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (float_all && standby_control_reg[gp1_pkg::CTL_WAKE4_BIT])
            |=> periph_in_o[gp1_pkg::PIN_WAKE_A] == $past(pin_sync[gp1_pkg::PIN_WAKE_A]);
    endproperty
    a_wake: assert property (p_wake) else $error("wake pin input blocked");
    // pin six blocked when its wake enable is clear
    property p_block;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (float_all && !standby_control_reg[gp1_pkg::CTL_WAKE6_BIT]) |=> !periph_in_o[gp1_pkg::PIN_WAKE_B];
    endproperty
    a_block: assert property (p_block) else $error("floated input not blocked");
    // peripheral enable drives its own level
    property p_periph;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (!float_all && periph_oe_i[7] && !OPEN_DRAIN[7])
            |=> pin_oe_o[7] && pin_o[7] == $past(periph_out_i[7]);
    endproperty
    a_periph: assert property (p_periph) else $error("peripheral drive lost");
    // pull-up follows its bit unless pin driven low
    property p_pullup;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (port_one_pullup_enable[1] && !(next_oe[1] && !next_val[1])) |=> pullup_en_o[1];
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up not connected");
    property p_float;
        @(posedge clk_sys_i) disable iff (!rst_n_i) float_all |=> pin_oe_o == '0;
    endproperty
    a_float: assert property (p_float) else $error("standby pins not floated");
    property p_rmw;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (rd_i && rmw_i && addr_i == gp1_pkg::OFS_DATA_LATCH && !wr_i) |=> rdata_o == $past(port_one_data_latch);
    endproperty
    a_rmw: assert property (p_rmw) else $error("rmw read not latch");
    property p_low_pu;
        @(posedge clk_sys_i) disable iff (!rst_n_i) (pin_oe_o[0] && !pin_o[0]) |-> !pullup_en_o[0];
    endproperty
    a_low_pu: assert property (p_low_pu) else $error("pull-up on while low");
    property p_nopu;
        @(posedge clk_sys_i) disable iff (!rst_n_i) !pullup_en_o[gp1_pkg::PIN_NO_PULLUP];
    endproperty
    a_nopu: assert property (p_nopu) else $error("pin two pull-up active");
    property p_write;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (wr_i && addr_i == gp1_pkg::OFS_DATA_LATCH) |=> port_one_data_latch == $past(wdata_i);
    endproperty
    a_write: assert property (p_write) else $error("latch write lost");
    property p_input;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (!float_all && !port_one_direction[1] && !periph_oe_i[1]) |=> !pin_oe_o[1];
    endproperty
    a_input: assert property (p_input) else $error("input pin driven");
endmodule : gp1_port

// ---- test/gp1_pad_model.sv ----
`timescale 1ns/1ps
// ************************************************************
// board side of the eight pins
// ************************************************************
module gp1_pad_model (
    // pad drive from the port
    input  wire logic [7:0] pin_o_i,
    input  wire logic [7:0] pin_oe_i,
    // board level on undriven pins
    input  wire logic [7:0] ext_i,
    // level seen back at the pads
    output logic      [7:0] pin_i_o
);
    // driven pins show the port, the rest the board
    assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_i);
endmodule : gp1_pad_model

// ---- test/gp1_port_bench.sv ----
`timescale 1ns/1ps
// ************************************************************
// port bench
// ************************************************************
module gp1_port_bench;
    logic       clk_sys_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, rmw_i = 1'b0, standby_i = 1'b0;
    logic [1:0] addr_i    = 2'h0;
    logic [7:0] wdata_i   = 8'h00, poe = 8'h00, pout = 8'h00, ext = 8'h00;
    logic [7:0] rdata_o, pin_i, pin_o, pin_oe_o, pullup_en_o, periph_in_o;
    int         mismatches = 0, compares = 0;
    // free running system clock
    always #4 clk_sys_i = ~clk_sys_i;
    // pin zero is open drain
    gp1_port #(.WIDTH(8), .OPEN_DRAIN(8'h01)) u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rmw_i(rmw_i), .rdata_o(rdata_o),
        .standby_i(standby_i), .periph_oe_i(poe), .periph_out_i(pout), .periph_in_o(periph_in_o),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pullup_en_o(pullup_en_o));
    gp1_pad_model u_pad (.pin_o_i(pin_o), .pin_oe_i(pin_oe_o), .ext_i(ext), .pin_i_o(pin_i));
    // compare and count
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        compares++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask : chk
    // one cycle write
    task automatic wr(logic [1:0] a, logic [7:0] d);
        @(posedge clk_sys_i); addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
        @(posedge clk_sys_i); wr_i <= 1'b0;
    endtask : wr
    // one cycle read, data judged in the following cycle
    task automatic rd(logic [1:0] a, logic m, string n, logic [7:0] e);
        @(posedge clk_sys_i); addr_i <= a; rd_i <= 1'b1; rmw_i <= m;
        @(posedge clk_sys_i); rd_i <= 1'b0; rmw_i <= 1'b0;
        #1 chk(n, e, rdata_o);
    endtask : rd
    // pin path is two sync flops plus output register
    task automatic settle;
        repeat (4) @(posedge clk_sys_i);
        #1;
    endtask : settle
    task automatic t_reset;
        rd(gp1_pkg::OFS_DIRECTION, 1'b0, "direction", 8'h00);
        chk("pin_oe", 8'h00, pin_oe_o);
    endtask : t_reset
    task automatic t_output;
        wr(gp1_pkg::OFS_DIRECTION, 8'hFF);
        wr(gp1_pkg::OFS_DATA_LATCH, 8'hA5);
        settle;
        chk("pin_oe", 8'hFE, pin_oe_o);
        chk("pin_o", 8'hA4, pin_o & 8'hFE);
        rd(gp1_pkg::OFS_DATA_LATCH, 1'b0, "latch", 8'hA5);
    endtask : t_output
    task automatic t_input;
        @(posedge clk_sys_i) ext <= 8'h96;
        wr(gp1_pkg::OFS_DIRECTION, 8'h0F);
        wr(gp1_pkg::OFS_DATA_LATCH, 8'h3C);
        settle;
        chk("pin_oe", 8'h0F, pin_oe_o);
        rd(gp1_pkg::OFS_DATA_LATCH, 1'b0, "pin read", 8'h9C);
        rd(gp1_pkg::OFS_DATA_LATCH, 1'b1, "rmw read", 8'h3C);
    endtask : t_input
    task automatic t_periph;
        @(posedge clk_sys_i) poe <= 8'h80;
        settle;
        chk("pin_oe", 8'h8F, pin_oe_o);
        rd(gp1_pkg::OFS_DATA_LATCH, 1'b0, "periph read", 8'h1C);
        @(posedge clk_sys_i) poe <= 8'h00;
    endtask : t_periph
    task automatic t_pull;
        wr(gp1_pkg::OFS_PULLUP, 8'hFF);
        wr(gp1_pkg::OFS_DIRECTION, 8'hFF);
        wr(gp1_pkg::OFS_DATA_LATCH, 8'h00);
        settle;
        chk("pullup low", 8'h00, pullup_en_o);
        wr(gp1_pkg::OFS_DATA_LATCH, 8'hFF);
        settle;
        chk("pullup high", 8'hFB, pullup_en_o);
        rd(gp1_pkg::OFS_PULLUP, 1'b0, "pullup reg", 8'hFF);
    endtask : t_pull
    task automatic t_standby;
        wr(gp1_pkg::OFS_PULLUP, 8'h00);
        wr(gp1_pkg::OFS_CONTROL, 8'h03);
        @(posedge clk_sys_i) begin ext <= 8'hFF; standby_i <= 1'b1; end
        settle;
        chk("float oe", 8'h00, pin_oe_o);
        chk("float in", 8'h10, periph_in_o);
        @(posedge clk_sys_i) standby_i <= 1'b0;
        wr(gp1_pkg::OFS_CONTROL, 8'h00);
        @(posedge clk_sys_i) standby_i <= 1'b1;
        settle;
        chk("hold oe", 8'hFE, pin_oe_o);
        chk("hold in", 8'hFF, periph_in_o);
        @(posedge clk_sys_i) standby_i <= 1'b0;
        wr(gp1_pkg::OFS_CONTROL, 8'h05);
        @(posedge clk_sys_i) standby_i <= 1'b1;
        settle;
        chk("wake six in", 8'h40, periph_in_o);
        @(posedge clk_sys_i) standby_i <= 1'b0;
    endtask : t_standby
    // verdict and end of run
    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    // main sequence
    initial begin
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        t_reset; t_output; t_input; t_periph; t_pull; t_standby;
        summarize;
    end
    // watchdog well beyond the roughly 85 cycles needed
    initial begin
        #20000;
        mismatches++;
        summarize;
    end
endmodule : gp1_port_bench
